// file: logic/fpsf_pkg.sv
// constants, layouts and encodings for the floating-point status field block
// assumes one core clock; registers reached over a 32-bit apb slave
//
// Behaviour
// R1 - controls: ftz bit0, wide exponent bit1, precision 3:2, rounding 5:4, override bit6
// R2 - six exception flags in bits 7..12, invalid lowest, inexact highest
// R3 - main field override bit always reads zero
// R4 - denormal flag sticky, set only when operand really enters a calculation
// R5 - software flag writes never interrupt; faults only from enabled exceptions
// R6 - flush-to-zero replaces tiny results with correctly signed zero
// R7 - flush-to-zero ignored while underflow exception enabled
// R8 - a flushed result sets underflow and inexact flags
// R9 - a flushed result signals inexact exception when inexact enabled
// R10 - static single/double ignore precision bits; range 8/11 or 17 bits
// R11 - dynamic precision 00/10/11 gives 24/53/64, 01 reserved; range 15 or 17
// R12 - parallel without completer: 24-bit precision, 8-bit range
// R13 - non-parallel without completer: 64-bit precision, 17-bit range
// R14 - rounding 00 nearest, 01 down, 10 up, 11 toward zero
// R15 - override set treats every trap disable bit as set
// R16 - six shared trap disable bits 0..5 suppress their exception's fault
// R17 - main field 18:6, alternates 31:19, 44:32, 57:45; instruction selects one
// R18 - flags stay set until software writes the field
package fpsf_pkg;
  localparam int unsigned FIELD_W   = 13;
  localparam int unsigned NUM_FIELD = 4;
  localparam int unsigned FLAG_W    = 6;
  localparam int unsigned BIT_FTZ   = 0;
  localparam int unsigned BIT_WRE   = 1;
  localparam int unsigned PREC_LO   = 2;
  localparam int unsigned RND_LO    = 4;
  localparam int unsigned BIT_OVR   = 6;
  localparam int unsigned FLAG_LO   = 7;
  localparam int unsigned EXC_INV   = 0;
  localparam int unsigned EXC_DEN   = 1;
  localparam int unsigned EXC_ZDV   = 2;
  localparam int unsigned EXC_OVF   = 3;
  localparam int unsigned EXC_UNF   = 4;
  localparam int unsigned EXC_INX   = 5;
  localparam int unsigned STAT_LO   = 6;
  localparam int unsigned STAT_HI_LO = 32;
  localparam logic [FIELD_W-1:0] FIELD_RST = 13'h0000;
  localparam logic [5:0] TRAPS_RST = 6'h00;
  // register byte offsets
  localparam logic [11:0] OFS_STAT_LO = 12'h000;
  localparam logic [11:0] OFS_STAT_HI = 12'h004;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h008;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h00c;
  localparam logic [11:0] OFS_SEL     = 12'h010;
  localparam logic [11:0] OFS_MODEL   = 12'h014;
  // completer encodings
  localparam logic [1:0] CMP_NONE = 2'h0;
  localparam logic [1:0] CMP_S    = 2'h1;
  localparam logic [1:0] CMP_D    = 2'h2;
  localparam logic [1:0] CMP_NA   = 2'h3;
  localparam logic [1:0] PREC_SGL = 2'h0;
  localparam logic [1:0] PREC_RSV = 2'h1;
  localparam logic [1:0] PREC_DBL = 2'h2;
  localparam logic [1:0] PREC_EXT = 2'h3;
  localparam logic [6:0] SIG_24 = 7'h18;
  localparam logic [6:0] SIG_53 = 7'h35;
  localparam logic [6:0] SIG_64 = 7'h40;
  localparam logic [4:0] EXP_8  = 5'h08;
  localparam logic [4:0] EXP_11 = 5'h0b;
  localparam logic [4:0] EXP_15 = 5'h0f;
  localparam logic [4:0] EXP_17 = 5'h11;
  typedef enum logic [1:0] {
    RND_NEAR  = 2'h0,
    RND_DOWN  = 2'h1,
    RND_UP    = 2'h2,
    RND_ZERO  = 2'h3
  } fpsf_round_t;
  localparam int unsigned IRQ_W = 2;
endpackage

// file: logic/fpsf_model_dec.sv
// computation model decoder: precision, exponent range and rounding
// purely combinational, fed from the selected status field
`timescale 1ns/1ps
`default_nettype none
module fpsf_model_dec
  import fpsf_pkg::*;
(
  input  wire logic [1:0]         completer,
  input  wire logic               parallelOp,
  input  wire logic [FIELD_W-1:0] field,
  output logic [6:0]              sigBits,
  output logic [4:0]              expBits,
  output logic                    modelRsvd,
  output fpsf_round_t             roundMode
);
  wire logic       wre  = field[BIT_WRE];
  wire logic [1:0] prec = field[PREC_LO+1:PREC_LO];
  assign roundMode = fpsf_round_t'(field[RND_LO+1:RND_LO]);  // [R14]
  always_comb begin
    sigBits   = SIG_64;
    expBits   = EXP_17;
    modelRsvd = 1'b0;
    case (completer)
      CMP_S: begin
        sigBits = SIG_24;  // [R10]
        expBits = wre ? EXP_17 : EXP_8;
      end
      CMP_D: begin
        sigBits = SIG_53;  // [R10]
        expBits = wre ? EXP_17 : EXP_11;
      end
      CMP_NONE: begin
        expBits = wre ? EXP_17 : EXP_15;  // [R11]
        case (prec)
          PREC_SGL: sigBits = SIG_24;
          PREC_DBL: sigBits = SIG_53;
          PREC_EXT: sigBits = SIG_64;
          default: modelRsvd = 1'b1;  // [R11]
        endcase
      end
      default: begin
        if (parallelOp) begin
          sigBits = SIG_24;  // [R12]
          expBits = EXP_8;
        end else begin
          sigBits = SIG_64;  // [R13]
          expBits = EXP_17;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// file: logic/fpsf_ctrl.sv
// status register with four status fields, traps, flag recording and apb slave
// datapath reports one instruction per opValid pulse on the same clock
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fpsf_ctrl
  import fpsf_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              opValid,
  input  wire logic [1:0]        opField,
  input  wire logic [1:0]        opCompleter,
  input  wire logic              opParallel,
  input  wire logic [FLAG_W-1:0] opExc,
  input  wire logic              opDenUsed,
  input  wire logic              opTiny,
  input  wire logic              opSign,
  output logic                   fpFault,
  output logic [FLAG_W-1:0]      fpFaultExc,
  output logic                   flushZero,
  output logic                   flushSign,
  output logic [6:0]             sigBits,
  output logic [4:0]             expBits,
  output logic                   modelRsvd,
  output logic [1:0]             roundSel,
  output logic                   irq
);
  import fpsf_pkg::*;

  logic [FIELD_W-1:0] field_q [NUM_FIELD];
  logic [5:0]         traps_q;
  logic [IRQ_W-1:0]   irqSt_q;
  logic [IRQ_W-1:0]   irqMsk_q;
  logic [1:0]         viewSel_q;
  logic [1:0]         viewCmp_q;
  logic               viewPar_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               fault_q;
  logic [FLAG_W-1:0]  faultExc_q;
  logic               flush_q;
  logic               flushSign_q;
  logic [6:0]         sig_q;
  logic [4:0]         exp_q;
  logic               rsvd_q;
  logic [1:0]         rnd_q;
  logic               irq_q;

  function automatic logic [FIELD_W-1:0] maskField(input logic [FIELD_W-1:0] v,
                                                   input int unsigned idx);
    logic [FIELD_W-1:0] r;
    r = v;
    if (idx == 0) begin
      r[BIT_OVR] = 1'b0;  // [R3]
    end
    return r;
  endfunction

  // apb decode
  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable & pready_q;
  wire logic wrAcc    = access & pwrite;
  wire logic rdAcc    = access & ~pwrite;
  wire logic hitLo    = paddr == OFS_STAT_LO;
  wire logic hitHi    = paddr == OFS_STAT_HI;
  wire logic hitIst   = paddr == OFS_IRQ_ST;
  wire logic hitImk   = paddr == OFS_IRQ_MSK;
  wire logic hitSel   = paddr == OFS_SEL;
  wire logic hitMod   = paddr == OFS_MODEL;
  wire logic mapped   = hitLo | hitHi | hitIst | hitImk | hitSel | hitMod;
  wire logic wrLo     = wrAcc & hitLo;
  wire logic wrHi     = wrAcc & hitHi;

  // full 64-bit status register image
  wire logic [63:0] statImage = {6'h00, maskField(field_q[3], 3), maskField(field_q[2], 2),
                                 maskField(field_q[1], 1), maskField(field_q[0], 0),
                                 traps_q};  // [R17]
  wire logic [63:0] wrImage = {pwdata, pwdata};

  // selected field for the current instruction
  wire logic [FIELD_W-1:0] selField = maskField(field_q[opField], opField);  // [R17]
  wire logic [FIELD_W-1:0] viewField = maskField(field_q[viewSel_q], viewSel_q);
  wire logic        ovr     = selField[BIT_OVR];
  wire logic [5:0]  effDis  = ovr ? 6'h3f : traps_q;  // [R15]
  wire logic [5:0]  enabled = ~effDis;  // [R16]
  wire logic        ftzOn   = selField[BIT_FTZ] & ~enabled[EXC_UNF];  // [R7]
  wire logic        flushNow = opValid & opTiny & ftzOn;  // [R6]

  // exception events seen this instruction
  logic [FLAG_W-1:0] excEv;
  always_comb begin
    excEv = opExc;
    excEv[EXC_DEN] = opExc[EXC_DEN] & opDenUsed;  // [R4]
    if (flushNow) begin
      excEv[EXC_UNF] = 1'b1;  // [R8]
      excEv[EXC_INX] = 1'b1;
    end
  end
  // only enabled events fault; a flushed result traps inexact if enabled
  wire logic [FLAG_W-1:0] faultVec = opValid ? (excEv & enabled) : 6'h00;  // [R5] [R9]

  wire logic [6:0] decSig;
  wire logic [4:0] decExp;
  wire logic       decRsvd;
  fpsf_round_t     decRnd;
  fpsf_model_dec u_dec (
    .completer  (opValid ? opCompleter : viewCmp_q),
    .parallelOp (opValid ? opParallel : viewPar_q),
    .field      (opValid ? selField : viewField),
    .sigBits    (decSig),
    .expBits    (decExp),
    .modelRsvd  (decRsvd),
    .roundMode  (decRnd)
  );

  wire logic [IRQ_W-1:0] irqEv = {flushNow, |faultVec};
  wire logic [31:0] modelWord = {16'h0000, decRsvd, decExp, decRnd, 1'b0, decSig};
  wire logic [31:0] rdMux =
    hitLo  ? statImage[31:0] :
    hitHi  ? statImage[63:32] :
    hitIst ? {30'h0, irqSt_q} :
    hitImk ? {30'h0, irqMsk_q} :
    hitSel ? {27'h0, viewPar_q, viewCmp_q, viewSel_q} :
    hitMod ? modelWord : 32'h0;

  genvar g;
  generate
    for (g = 0; g < NUM_FIELD; g++) begin : gField
      localparam int unsigned LO = STAT_LO + g * FIELD_W;
      wire logic swWr = (LO + FIELD_W <= 32) ? wrLo :
                        (LO >= 32) ? wrHi : (wrLo | wrHi);
      logic [FIELD_W-1:0] wrVal;
      always_comb begin
        wrVal = field_q[g];
        for (int b = 0; b < FIELD_W; b++) begin
          if (((LO + b) < 32 && wrLo) || ((LO + b) >= 32 && wrHi)) begin
            wrVal[b] = wrImage[LO + b];
          end
        end
      end
      logic [FIELD_W-1:0] field_d;
      always_comb begin
        field_d = swWr ? wrVal : field_q[g];  // [R5]
        if (opValid && opField == 2'(g)) begin
          // hardware set wins over a simultaneous software clear
          field_d[FLAG_LO +: FLAG_W] = field_d[FLAG_LO +: FLAG_W] | excEv;  // [R2] [R18]
        end
        field_d = maskField(field_d, g);  // [R1] [R3]
      end
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          field_q[g] <= FIELD_RST;
        end else begin
          field_q[g] <= field_d;
        end
      end
    end
  endgenerate

  wire logic [IRQ_W-1:0] irqSt_d = ((rdAcc & hitIst) ? {IRQ_W{1'b0}} : irqSt_q) | irqEv;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      traps_q     <= TRAPS_RST;
      irqSt_q     <= '0;
      irqMsk_q    <= '0;
      viewSel_q   <= 2'h0;
      viewCmp_q   <= CMP_NONE;
      viewPar_q   <= 1'b0;
      prdata_q    <= 32'h0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      fault_q     <= 1'b0;
      faultExc_q  <= '0;
      flush_q     <= 1'b0;
      flushSign_q <= 1'b0;
      sig_q       <= SIG_64;
      exp_q       <= EXP_17;
      rsvd_q      <= 1'b0;
      rnd_q       <= RND_NEAR;
      irq_q       <= 1'b0;
    end else begin
      if (wrLo) begin
        traps_q <= pwdata[5:0];  // [R16]
      end
      if (wrAcc && hitImk) begin
        irqMsk_q <= pwdata[IRQ_W-1:0];
      end
      if (wrAcc && hitSel) begin
        viewSel_q <= pwdata[1:0];
        viewCmp_q <= pwdata[3:2];
        viewPar_q <= pwdata[4];
      end
      irqSt_q     <= irqSt_d;
      // no wait state: ready answers the cycle after setup
      pready_q    <= setup;
      pslverr_q   <= setup & ~mapped;
      prdata_q    <= (setup & ~pwrite) ? rdMux : 32'h0;
      fault_q     <= |faultVec;
      faultExc_q  <= faultVec;
      flush_q     <= flushNow;
      flushSign_q <= flushNow & opSign;  // [R6]
      sig_q       <= decSig;
      exp_q       <= decExp;
      rsvd_q      <= decRsvd;
      rnd_q       <= decRnd;
      irq_q       <= |(irqSt_d & irqMsk_q);
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign fpFault    = fault_q;
  assign fpFaultExc = faultExc_q;
  assign flushZero  = flush_q;
  assign flushSign  = flushSign_q;
  assign sigBits    = sig_q;
  assign expBits    = exp_q;
  assign modelRsvd  = rsvd_q;
  assign roundSel   = rnd_q;
  assign irq        = irq_q;
endmodule
`default_nettype wire

// file: tb/fpsf_props.sv
// port assertions for the status field block
// bound to fpsf_ctrl; one core clock domain
`timescale 1ns/1ps
`default_nettype none
module fpsf_props
  import fpsf_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              opValid,
  input wire logic [1:0]        opCompleter,
  input wire logic              opParallel,
  input wire logic [FLAG_W-1:0] opExc,
  input wire logic              opTiny,
  input wire logic              opSign,
  input wire logic              fpFault,
  input wire logic [FLAG_W-1:0] fpFaultExc,
  input wire logic              flushZero,
  input wire logic              flushSign,
  input wire logic [6:0]        sigBits,
  input wire logic [4:0]        expBits
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_fault_has_cause: assert property (
    fpFault |-> $past(opValid) && ($past(opExc) != 6'h00 || $past(opTiny)))
    else $error("fault without a reporting op");
  a_fault_exc_set: assert property (
    fpFault |-> fpFaultExc != 6'h00 &&
      (fpFaultExc & ~($past(opExc) | {$past(opTiny), 5'h00})) == 6'h00)
    else $error("fault for an unreported exception");
  a_flush_sign_kept: assert property (
    flushZero |-> $past(opValid && opTiny) && flushSign == $past(opSign))
    else $error("flush without tiny result or wrong sign");
  a_flush_no_unf: assert property (
    flushZero |-> !fpFaultExc[EXC_UNF])
    else $error("underflow fault on a flushed result");
  a_single_model: assert property (
    opValid && opCompleter == CMP_S |=> sigBits == SIG_24 && (expBits == EXP_8 || expBits == EXP_17))
    else $error("single completer model wrong");
  a_double_model: assert property (
    opValid && opCompleter == CMP_D |=> sigBits == SIG_53 && (expBits == EXP_11 || expBits == EXP_17))
    else $error("double completer model wrong");
  a_pair_model: assert property (
    opValid && opCompleter == CMP_NA && opParallel |=> sigBits == SIG_24 && expBits == EXP_8)
    else $error("parallel model wrong");
  a_scalar_model: assert property (
    opValid && opCompleter == CMP_NA && !opParallel |=> sigBits == SIG_64 && expBits == EXP_17)
    else $error("non-parallel model wrong");
  c_flush: cover property (flushZero);
  c_fault: cover property (fpFault);
  c_pair: cover property (opValid && opParallel && opCompleter == CMP_NA);
endmodule
bind fpsf_ctrl fpsf_props u_props (.sys_clk, .rst_b, .opValid, .opCompleter, .opParallel,
  .opExc, .opTiny, .opSign, .fpFault, .fpFaultExc, .flushZero, .flushSign, .sigBits, .expBits);
`default_nettype wire

// file: tb/fpsf_dp_model.sv
// datapath stand-in: reports one instruction result per issue call
// drives the op inputs of fpsf_ctrl on the core clock
`timescale 1ns/1ps
`default_nettype none
module fpsf_dp_model
  import fpsf_pkg::*;
(
  input  wire logic         sys_clk,
  output logic              opValid,
  output logic [1:0]        opField,
  output logic [1:0]        opCompleter,
  output logic              opParallel,
  output logic [FLAG_W-1:0] opExc,
  output logic              opDenUsed,
  output logic              opTiny,
  output logic              opSign
);
  logic [13:0] opQ;
  assign {opField, opCompleter, opParallel, opExc, opDenUsed, opTiny, opSign} = opQ;
  initial begin
    opValid = 1'b0;
    opQ = 14'h0000;
  end
  task automatic issue(input logic [1:0] f, input logic [1:0] c, input logic p,
                       input logic [5:0] e, input logic d, input logic t, input logic s);
    @(posedge sys_clk);
    opValid <= 1'b1;
    opQ <= {f, c, p, e, d, t, s};
    @(posedge sys_clk);
    opValid <= 1'b0;
    // qualifiers mean nothing outside the pulse, so show garbage, not the old value
    opQ <= ~opQ;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_fp_status_field_control.sv
// self-checking bench for the floating-point status field block
// apb driven here; datapath results come through fpsf_dp_model
`timescale 1ns/1ps
`default_nettype none
module tb_fp_status_field_control;
  import fpsf_pkg::*;
  logic              sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rdData;
  logic              opValid, opParallel, opDenUsed, opTiny, opSign, fpFault;
  logic              flushZero, flushSign, modelRsvd, errSeen;
  logic [1:0]        opField, opCompleter, roundSel;
  logic [FLAG_W-1:0] opExc, fpFaultExc;
  logic [6:0]        sigBits;
  logic [4:0]        expBits;
  int                n_errors, tests_run;
  fpsf_ctrl u_dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .opValid, .opField, .opCompleter, .opParallel, .opExc, .opDenUsed,
    .opTiny, .opSign, .fpFault, .fpFaultExc, .flushZero, .flushSign, .sigBits, .expBits,
    .modelRsvd, .roundSel, .irq);
  fpsf_dp_model u_dp (.sys_clk, .opValid, .opField, .opCompleter, .opParallel, .opExc,
    .opDenUsed, .opTiny, .opSign);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    errSeen = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      n_errors++;
      $display("ERROR pready expected 1 seen %b", pready);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffff_ffff);
    acc(1'b0, a, 32'h0);
    chk(nm, e & m, rdData & m);
  endtask
  task automatic s_layout();
    rd("statLo", OFS_STAT_LO, 32'h0000_0000);
    wr(OFS_STAT_LO, 32'hffff_ffc0); // traps enabled, field 0 and 1 flags set by software
    rd("statLo", OFS_STAT_LO, 32'hffff_efc0);
    rd("irqStatus", OFS_IRQ_ST, 32'h0);
    wr(OFS_STAT_HI, 32'hffff_ffff);
    rd("statHi", OFS_STAT_HI, 32'h03ff_ffff);
    rd("unmapped", 12'h020, 32'h0);
    chk("pslverr", 1'b1, errSeen);
  endtask
  task automatic s_model();
    for (int p = 0; p < 4; p++) begin
      wr(OFS_STAT_LO, {20'h0, 2'(p), 2'(p), 1'(p == 3), 7'h0});
      rd("model", OFS_MODEL, {16'h0, 1'(p == 1), (p == 3) ? EXP_17 : EXP_15, 2'(p), 1'b0,
         (p == 0) ? SIG_24 : (p == 2) ? SIG_53 : SIG_64},
         (p == 1) ? 32'h0000_8300 : 32'hffff_ffff);
      chk("roundSel", 32'(p), roundSel);
      chk("modelRsvd", 32'(p == 1), modelRsvd);
    end
    // main field now has wide exponent on, so static completers give 17-bit range
    for (int k = 1; k < 5; k++) begin
      u_dp.issue(2'h0, (k > 2) ? CMP_NA : 2'(k), 1'(k == 3), 6'h0, 1'b0, 1'b0,
                 1'b0);
      #1;
      chk("sigBits", (k == 2) ? SIG_53 : (k == 4) ? SIG_64 : SIG_24, sigBits);
      chk("expBits", (k == 3) ? EXP_8 : EXP_17, expBits);
    end
    wr(OFS_SEL, 32'h0000_0009); // field 1, double completer
    rd("viewSel", OFS_SEL, 32'h0000_0009);
    rd("model", OFS_MODEL, 32'h0000_2c35);
    wr(OFS_SEL, 32'h0000_001d); // field 1, completer not applicable, parallel
    rd("model", OFS_MODEL, 32'h0000_2018);
    wr(OFS_SEL, 32'h0);
  endtask
  task automatic s_flush();
    wr(OFS_STAT_LO, 32'h0000_0050); // underflow trap off, main field flush on
    u_dp.issue(2'h0, CMP_S, 1'b0, 6'h00, 1'b0, 1'b1, 1'b1);
    #1;
    chk("flushZero", 1'b1, flushZero);
    chk("flushSign", 1'b1, flushSign);
    chk("fpFaultExc", 6'h20, fpFaultExc);
    rd("statLo", OFS_STAT_LO, 32'h0006_0050);
    chk("irq", 1'b1, irq);
    rd("irqStatus", OFS_IRQ_ST, 32'h3);
    @(posedge sys_clk);
    #1;
    chk("irq", 1'b0, irq);
    wr(OFS_IRQ_MSK, 32'h0);
    wr(OFS_STAT_LO, 32'h0000_0040); // underflow enabled, flush requested
    u_dp.issue(2'h0, CMP_S, 1'b0, 6'h10, 1'b0, 1'b1, 1'b0);
    #1;
    chk("flushZero", 1'b0, flushZero);
    chk("fpFaultExc", 6'h10, fpFaultExc);
    rd("statLo", OFS_STAT_LO, 32'h0002_0040);
    chk("irq", 1'b0, irq);
    rd("irqStatus", OFS_IRQ_ST, 32'h1);
  endtask
  task automatic s_den();
    wr(OFS_STAT_LO, 32'h0000_003f); // every shared trap disabled
    u_dp.issue(2'h0, CMP_D, 1'b0, 6'h02, 1'b0, 1'b0, 1'b0);
    rd("statLo", OFS_STAT_LO, 32'h0000_003f);
    u_dp.issue(2'h0, CMP_D, 1'b0, 6'h02, 1'b1, 1'b0, 1'b0);
    #1;
    chk("fpFault", 1'b0, fpFault);
    u_dp.issue(2'h0, CMP_D, 1'b0, 6'h00, 1'b0, 1'b0, 1'b0);
    rd("statLo", OFS_STAT_LO, 32'h0000_403f);
  endtask
  task automatic s_override();
    wr(OFS_STAT_LO, 32'h0200_0000); // field 1 override set, shared traps enabled
    u_dp.issue(2'h1, CMP_D, 1'b0, 6'h01, 1'b0, 1'b0, 1'b0);
    #1;
    chk("fpFault", 1'b0, fpFault);
    rd("statLo", OFS_STAT_LO, 32'h0600_0000);
    wr(OFS_STAT_LO, 32'h0);
    u_dp.issue(2'h1, CMP_D, 1'b0, 6'h21, 1'b0, 1'b0, 1'b0);
    #1;
    chk("fpFaultExc", 6'h21, fpFaultExc);
    rd("statLo", OFS_STAT_LO, 32'h8400_0000);
  endtask
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    wr(OFS_IRQ_MSK, 32'h3);
    s_layout();
    s_model();
    s_flush();
    s_den();
    s_override();
    end_of_test();
  end
endmodule
`default_nettype wire
